// ===== design/adc_result_map.svh
// constants for the serial result port
`ifndef ADC_RESULT_MAP_SVH
`define ADC_RESULT_MAP_SVH
`define RESULT_BITS    14
`define SHIFT_STEPS    15
`define STEP_WIDTH     5
`define STEP_ZERO      5'h0
`define STEP_CLOSE     5'h10
`define RESULT_ZERO    14'h0000
`endif

// ===== design/adc_result_pkg.sv
// types for the serial result port
package adc_result_pkg;
  typedef enum logic [1:0] {
    IDLE  = 2'b01,
    SHIFT = 2'b10
  } frame_state_t;
endpackage

// ===== design/adc_serial_result_port.sv
// serial result port of the converter: buffer plus shift-out frame
// Notes on behaviour
// - chip select falling starts driving the serial result output
// - chip select high keeps the output floating
// - bits keep coming after select falls until the lsb is out
// - msb first, first bit present before any serial clock edge
// - each later bit is placed on a rising serial clock edge
// - seventeenth rising clock edge floats the output, select low or not
// - a frame ended early floats the output on select rising
// - each frame carries fourteen bits: a buffered conversion value, or zeros when the buffer is empty
`timescale 1ns/100ps
`include "adc_result_map.svh"
module adc_serial_result_port #(
  parameter int WIDTH = `RESULT_BITS
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] resultData,
  input  wire logic             resultValid,
  output logic                  resultReady,
  input  wire logic             chipSelectN,
  input  wire logic             serialClock,
  output logic                  serialResultOut,
  output logic                  serialResultOe
);
  // two-entry buffer; a word held by a busy link waits here
  logic [WIDTH-1:0] bufMem [2];
  logic             wrPtr;
  logic             rdPtr;
  logic [1:0]       bufCount;
  logic             bufValid;
  logic             bufTake;

  assign resultReady = (bufCount != 2'd2);
  assign bufValid    = (bufCount != 2'd0);

  always_ff @(posedge clock) begin
    if (reset) begin
      wrPtr    <= 1'b0;
      rdPtr    <= 1'b0;
      bufCount <= 2'd0;
    end else begin
      if (resultValid && resultReady) begin
        bufMem[wrPtr] <= resultData;
        wrPtr         <= ~wrPtr;
      end
      if (bufTake) begin
        rdPtr <= ~rdPtr;
      end
      bufCount <= bufCount + 2'(resultValid && resultReady)
                           - 2'(bufTake);
    end
  end

  // pins are foreign to this clock: two flops before use
  logic [1:0] csSync;
  logic [1:0] sckSync;
  logic       csLast;
  logic       sckLast;
  always_ff @(posedge clock) begin
    if (reset) begin
      csSync  <= 2'b11;
      // reset high: a host idling high gives no false rise
      sckSync <= 2'b11;
      csLast  <= 1'b1;
      sckLast <= 1'b1;
    end else begin
      csSync  <= {csSync[0], chipSelectN};
      sckSync <= {sckSync[0], serialClock};
      csLast  <= csSync[1];
      sckLast <= sckSync[1];
    end
  end

  logic csFall;
  logic csHigh;
  logic sckRise;
  assign csHigh  = csSync[1];
  assign csFall  = csLast && !csSync[1];
  assign sckRise = !sckLast && sckSync[1];

  adc_result_pkg::frame_state_t state;
  logic [`STEP_WIDTH-1:0] step;
  logic [WIDTH-1:0]       shiftReg;
  logic                   haveWord;

  // with no word ready the frame sends zeros rather than stalling
  assign bufTake = csFall && bufValid;

  always_ff @(posedge clock) begin
    if (reset) begin
      state           <= adc_result_pkg::IDLE;
      step            <= `STEP_ZERO;
      shiftReg        <= `RESULT_ZERO;
      serialResultOut <= 1'b0;
      serialResultOe  <= 1'b0;
      haveWord        <= 1'b0;
    end else begin
      case (state)
        adc_result_pkg::IDLE: begin
          serialResultOe <= 1'b0;
          if (csFall) begin
            state           <= adc_result_pkg::SHIFT;
            step            <= `STEP_ZERO;
            haveWord        <= bufValid;
            // msb out before any clock edge
            shiftReg        <= bufValid ? bufMem[rdPtr] << 1
                                        : `RESULT_ZERO;
            serialResultOut <= bufValid ? bufMem[rdPtr][WIDTH-1]
                                        : 1'b0;
            serialResultOe  <= 1'b1;
          end
        end
        adc_result_pkg::SHIFT: begin
          if (csHigh) begin
            state          <= adc_result_pkg::IDLE;
            serialResultOe <= 1'b0;
          end else if (sckRise) begin
            step <= step + 5'd1;
            if (step == `STEP_CLOSE) begin
              state          <= adc_result_pkg::IDLE;
              serialResultOe <= 1'b0;
            end else begin
              // past the lsb the line idles low until the close
              serialResultOut <= shiftReg[WIDTH-1];
              shiftReg        <= shiftReg << 1;
            end
          end
        end
        default: begin
          state          <= adc_result_pkg::IDLE;
          serialResultOe <= 1'b0;
        end
      endcase
    end
  end

  // a finished frame with select still low waits for select high
  logic waitHigh;
  always_ff @(posedge clock) begin
    if (reset) begin
      waitHigh <= 1'b0;
    end else if (csHigh) begin
      waitHigh <= 1'b0;
    end else if (state == adc_result_pkg::SHIFT && sckRise
                 && step == `STEP_CLOSE) begin
      waitHigh <= 1'b1;
    end
  end

  property p_float_high;
    @(posedge clock) disable iff (reset)
    csSync[1] && $past(csSync[1]) |-> !serialResultOe;
  endproperty
  a_float_high: assert property (p_float_high)
    else $error("output driven while select high");

  property p_drive_fall;
    @(posedge clock) disable iff (reset)
    csFall && state == adc_result_pkg::IDLE |=> serialResultOe;
  endproperty
  a_drive_fall: assert property (p_drive_fall)
    else $error("select fall did not drive output");

  property p_msb_first;
    @(posedge clock) disable iff (reset)
    csFall && state == adc_result_pkg::IDLE && bufValid
      |=> serialResultOut == $past(bufMem[rdPtr][WIDTH-1]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("first bit is not the msb");

  property p_change_on_rise;
    @(posedge clock) disable iff (reset)
    state == adc_result_pkg::SHIFT && !sckRise
      |=> $stable(serialResultOut);
  endproperty
  a_change_on_rise: assert property (p_change_on_rise)
    else $error("output changed without rising clock");

  property p_close_17;
    @(posedge clock) disable iff (reset)
    state == adc_result_pkg::SHIFT && !csHigh && sckRise
      && step == `STEP_CLOSE |=> !serialResultOe;
  endproperty
  a_close_17: assert property (p_close_17)
    else $error("output not floated at seventeenth edge");

  property p_stay_closed;
    @(posedge clock) disable iff (reset)
    waitHigh |-> !serialResultOe;
  endproperty
  a_stay_closed: assert property (p_stay_closed)
    else $error("output driven after frame close");

  property p_early_end;
    @(posedge clock) disable iff (reset)
    state == adc_result_pkg::SHIFT && csHigh |=> !serialResultOe;
  endproperty
  a_early_end: assert property (p_early_end)
    else $error("output not floated on select rise");

  property p_hold_low;
    @(posedge clock) disable iff (reset)
    state == adc_result_pkg::SHIFT && !csHigh && step < `SHIFT_STEPS
      |=> serialResultOe;
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("output dropped before the lsb");

  property p_buf_bound;
    @(posedge clock) disable iff (reset)
    bufCount <= 2'd2;
  endproperty
  a_buf_bound: assert property (p_buf_bound)
    else $error("buffer overrun");

  // a frame opened on an empty buffer must stay all zeros
  property p_empty_zero;
    @(posedge clock) disable iff (reset)
    state == adc_result_pkg::SHIFT && !haveWord |-> !serialResultOut;
  endproperty
  a_empty_zero: assert property (p_empty_zero)
    else $error("empty frame sent a one");
endmodule

// ===== tb/spi_host_model.sv
// host serial port model for the result port
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic clock,
  input  wire logic sdoLine,
  output logic      chipSelectN,
  output logic      serialClock
);
  // clock idles high and stands still between frames
  initial begin
    chipSelectN = 1'b1;
    serialClock = 1'b1;
  end
  task automatic half;
    repeat (4) @(posedge clock);
  endtask
  task automatic frame(input int rises, output logic [13:0] word);
    chipSelectN <= 1'b0;
    for (int i = 0; i < rises; i++) begin
      half;
      // host takes each bit as its clock falls
      if (i < 14) word = {word[12:0], sdoLine};
      serialClock <= 1'b0;
      half;
      serialClock <= 1'b1;
    end
    half;
    half;
  endtask
  task automatic close;
    chipSelectN <= 1'b1;
    half;
  endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the serial result port
`timescale 1ns/100ps
module testbench;
  logic        clock;
  logic        reset;
  logic [13:0] resultData;
  logic        resultValid;
  logic        resultReady;
  logic        chipSelectN;
  logic        serialClock;
  logic        serialResultOut;
  logic        serialResultOe;
  logic        lastBit;
  logic        sdoLine;
  logic [13:0] word;
  int          fails = 0;
  int          total_checks = 0;
  int          cycles = 0;
  adc_serial_result_port dut (
    .clock(clock), .reset(reset), .resultData(resultData),
    .resultValid(resultValid), .resultReady(resultReady),
    .chipSelectN(chipSelectN), .serialClock(serialClock),
    .serialResultOut(serialResultOut), .serialResultOe(serialResultOe));
  spi_host_model host (.clock(clock), .sdoLine(sdoLine),
    .chipSelectN(chipSelectN), .serialClock(serialClock));
  // floated line shows the inverse of its last driven level
  always @(posedge clock) begin
    if (reset) begin
      lastBit <= 1'b0;
    end else if (serialResultOe) begin
      lastBit <= serialResultOut;
    end
  end
  assign sdoLine = serialResultOe ? serialResultOut : ~lastBit;
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      summarize;
    end
  end
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic push(input logic [13:0] d);
    resultData <= d;
    resultValid <= 1'b1;
    do @(posedge clock); while (resultReady !== 1'b1);
    resultValid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic take(input int rises, input logic [13:0] exp,
                      input logic oeExp);
    host.frame(rises, word);
    check(word, exp);
    check(serialResultOe, oeExp);
    host.close;
    check(serialResultOe, 1'b0);
  endtask
  task automatic test_reset;
    check(resultReady, 1'b1);
    check(serialResultOe, 1'b0);
    $display("test reset done");
  endtask
  task automatic test_full_close17;
    push(14'h2A5C);
    push(14'h1F03);
    // third word waits while both entries are full
    fork
      push(14'h3FFF);
      begin
        repeat (2) @(posedge clock);
        check(resultReady, 1'b0);
        take(17, 14'h2A5C, 1'b0);
      end
    join
    $display("test full buffer and close done");
  endtask
  task automatic test_early_end;
    take(14, 14'h1F03, 1'b1);
    take(14, 14'h3FFF, 1'b1);
    $display("test early end done");
  endtask
  // empty buffer at select fall sends zeros
  task automatic test_empty;
    take(14, 14'h0000, 1'b1);
    $display("test empty buffer done");
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    resultData = 14'h0000;
    resultValid = 1'b0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    // select stays high while the synchronisers settle
    repeat (3) @(posedge clock);
    test_reset;
    test_full_close17;
    test_early_end;
    test_empty;
    summarize;
  end
endmodule
